// ---- core/pjs_defs.svh ----
// offsets, field positions, reset values and timing counts of the
// print job session block; assumes byte addresses on a 32-bit bus
`ifndef PJS_DEFS_SVH
`define PJS_DEFS_SVH
`define PJS_A_SERCFG  10'h000
`define PJS_A_TMO     10'h004
`define PJS_A_JOBCFG  10'h008
`define PJS_A_DFLT    10'h00c
`define PJS_A_PRNMAP  10'h010
`define PJS_A_DISC    10'h014
`define PJS_A_MSGLEN  10'h018
`define PJS_A_STATUS  10'h01c
`define PJS_SC_WORD8  0
`define PJS_SC_STOP2  1
`define PJS_SC_PAR    3:2
`define PJS_SC_XTX    4
`define PJS_SC_XRX    5
`define PJS_SC_BIDIR  6
`define PJS_SC_WIRE8  7
`define PJS_SC_BAUD   11:8
`define PJS_JC_FFPRE  0
`define PJS_JC_FFPOST 1
`define PJS_JC_BANEN  2
`define PJS_JC_BANAFT 3
`define PJS_JC_BEGIN  4
`define PJS_SERCFG_RST 12'h5c1
`define PJS_JOBCFG_RST 5'h00
`define PJS_TMO_RST   8'h14
`define PJS_TMO_MAX   8'hc8
`define PJS_DISC_RST  8'h04
`define PJS_BAUD_BIDIR 4'h8
`define PJS_BAUD_MAX  4'ha
`define PJS_MSG_MAX   7'h50
`define PJS_NAME_LEN  7'h10
`define PJS_CH_FF     8'h0c
`define PJS_CH_XON    8'h11
`define PJS_CH_XOFF   8'h13
`define PJS_CLK_NS    20
`define PJS_SEC_NS    1000000000
`endif

// ---- core/pjs_pkg.sv ----
// types of the print job session block
// assumes nothing of its surroundings
package pjs_pkg;
  typedef enum logic [2:0] {
    PJS_IDLE     = 3'b000,
    PJS_FF_PRE   = 3'b001,
    PJS_BAN_PRE  = 3'b010,
    PJS_DATA     = 3'b011,
    PJS_BAN_POST = 3'b100,
    PJS_FF_POST  = 3'b101
  } pjs_state_t;
endpackage

// ---- core/pjs_session.sv ----
// print job session control for one computer port
// assumes a byte stream from the host port and a printer-side sink on
// the same clock, and a select code parser that pulses sel_valid
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pjs_defs.svh"
module pjs_session
  import pjs_pkg::*;
#(
  parameter int TICK_CYCLES = `PJS_SEC_NS / `PJS_CLK_NS
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  output logic             in_ready,
  input  wire logic        sel_valid,
  input  wire logic [4:0]  sel_id,
  input  wire logic        prn_rx_valid,
  input  wire logic [7:0]  prn_rx_data,
  output logic             out_valid,
  output logic      [7:0]  out_data,
  input  wire logic        out_ready,
  output logic      [4:0]  out_prn,
  output logic             cfg_word8,
  output logic             cfg_stop2,
  output logic      [1:0]  cfg_parity,
  output logic      [3:0]  cfg_baud,
  output logic             cfg_wire8,
  output logic             cfg_bidir,
  output logic             host_stop,
  output logic             job_active
);
  logic [11:0] sercfg_reg, sercfg_next;
  logic [4:0]  jobcfg_reg, jobcfg_next;
  logic [7:0]  tmo_reg, tmo_next, disc_reg, disc_next;
  logic [4:0]  dflt_reg, dflt_next;
  logic [31:0] prnmap_reg, prnmap_next;
  logic [6:0]  msglen_reg, msglen_next;
  logic        wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  msg_mem [80];
  logic [7:0]  name_mem [16];
  logic        wr_ok, msg_hit, name_hit;
  logic [6:0]  msg_idx;

  pjs_state_t  state_reg, state_next;
  logic        hold_v_reg, hold_v_next;
  logic [7:0]  hold_d_reg, hold_d_next;
  logic        rdy_reg, rdy_next;
  logic [7:0]  b0_reg, b0_next, b1_reg, b1_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic        ov_reg, ov_next;
  logic        pause_reg, pause_next;
  logic        hstop_reg, hstop_next;
  logic        act_reg, act_next;
  logic [4:0]  cur_reg, cur_next, pend_reg, pend_next;
  logic        pend_v_reg, pend_v_next;
  logic [6:0]  idx_reg, idx_next;
  logic [25:0] tick_reg, tick_next;
  logic [7:0]  sec_reg, sec_next;
  logic        accept, pop, push, space, expire, tick, ban_last;
  logic [7:0]  pbyte, bbyte;
  logic [1:0]  c_after;

  function automatic logic [3:0] baud_cap(input logic [3:0] code,
                                          input logic bidir);
    logic [3:0] c;
    c = (code > `PJS_BAUD_MAX) ? `PJS_BAUD_MAX : code;
    if (bidir && c > `PJS_BAUD_BIDIR) c = `PJS_BAUD_BIDIR;
    return c;
  endfunction

  assign msg_idx  = avs_address[8:2];
  assign msg_hit  = avs_address[9] && msg_idx < `PJS_MSG_MAX;
  assign name_hit = avs_address[9:6] == 4'h4;
  assign wr_ok    = avs_write && !wait_reg;

  // register file and bus answer
  always_comb begin
    sercfg_next = sercfg_reg;
    jobcfg_next = jobcfg_reg;
    tmo_next    = tmo_reg;
    disc_next   = disc_reg;
    dflt_next   = dflt_reg;
    prnmap_next = prnmap_reg;
    msglen_next = msglen_reg;
    wait_next   = !((avs_read || avs_write) && wait_reg);
    rdata_next  = rdata_reg;
    if (wr_ok) begin
      unique case (avs_address)
        `PJS_A_SERCFG: begin
          sercfg_next = avs_writedata[11:0];
          sercfg_next[`PJS_SC_BAUD] = baud_cap(
            avs_writedata[`PJS_SC_BAUD], avs_writedata[`PJS_SC_BIDIR]);
        end
        `PJS_A_TMO:
          tmo_next = (avs_writedata[7:0] > `PJS_TMO_MAX)
                     ? `PJS_TMO_MAX : avs_writedata[7:0];
        `PJS_A_JOBCFG: jobcfg_next = avs_writedata[4:0];
        `PJS_A_DFLT:
          if (avs_writedata[4:0] == 5'h00 ||
              prnmap_reg[avs_writedata[4:0]])
            dflt_next = avs_writedata[4:0];
        `PJS_A_PRNMAP: prnmap_next = avs_writedata;
        `PJS_A_DISC:   disc_next = avs_writedata[7:0];
        `PJS_A_MSGLEN:
          msglen_next = (avs_writedata[6:0] > `PJS_MSG_MAX)
                        ? `PJS_MSG_MAX : avs_writedata[6:0];
        default: ;
      endcase
    end
    if (avs_read && wait_reg) begin
      rdata_next = 32'h0000_0000;
      unique case (avs_address)
        `PJS_A_SERCFG: rdata_next[11:0] = sercfg_reg;
        `PJS_A_TMO:    rdata_next[7:0]  = tmo_reg;
        `PJS_A_JOBCFG: rdata_next[4:0]  = jobcfg_reg;
        `PJS_A_DFLT:   rdata_next[4:0]  = dflt_reg;
        `PJS_A_PRNMAP: rdata_next       = prnmap_reg;
        `PJS_A_DISC:   rdata_next[7:0]  = disc_reg;
        `PJS_A_MSGLEN: rdata_next[6:0]  = msglen_reg;
        `PJS_A_STATUS:
          rdata_next[24:0] = {pause_reg, sec_reg, 7'h00, cur_reg,
                              state_reg, state_reg != PJS_IDLE};
        default: begin
          if (msg_hit)  rdata_next[7:0] = msg_mem[msg_idx];
          if (name_hit) rdata_next[7:0] = name_mem[avs_address[5:2]];
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sercfg_reg <= `PJS_SERCFG_RST;
      jobcfg_reg <= `PJS_JOBCFG_RST;
      tmo_reg    <= `PJS_TMO_RST;
      disc_reg   <= `PJS_DISC_RST;
      dflt_reg   <= 5'h00;
      prnmap_reg <= 32'h0000_0000;
      msglen_reg <= 7'h00;
      wait_reg   <= 1'b1;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      sercfg_reg <= sercfg_next;
      jobcfg_reg <= jobcfg_next;
      tmo_reg    <= tmo_next;
      disc_reg   <= disc_next;
      dflt_reg   <= dflt_next;
      prnmap_reg <= prnmap_next;
      msglen_reg <= msglen_next;
      wait_reg   <= wait_next;
      rdata_reg  <= rdata_next;
    end
  end

  // banner text store, no reset
  always_ff @(posedge clock) begin
    if (wr_ok && msg_hit)  msg_mem[msg_idx] <= avs_writedata[7:0];
    if (wr_ok && name_hit) name_mem[avs_address[5:2]] <= avs_writedata[7:0];
  end

  assign accept   = in_valid && rdy_reg;
  assign pop      = ov_reg && out_ready;
  assign space    = cnt_reg != 2'h2;
  assign tick     = tick_reg == 26'(TICK_CYCLES - 1);
  assign expire   = state_reg == PJS_DATA && tmo_reg != 8'h00
                    && sec_reg == tmo_reg;
  assign bbyte    = (idx_reg < msglen_reg) ? msg_mem[idx_reg]
                    : name_mem[4'(idx_reg - msglen_reg)];
  assign ban_last = idx_reg == msglen_reg + `PJS_NAME_LEN - 7'h01;

  // job sequencer, input hold, output buffer and inactivity timer
  always_comb begin
    state_next  = state_reg;
    cur_next    = cur_reg;
    pend_next   = pend_reg;
    pend_v_next = pend_v_reg;
    idx_next    = idx_reg;
    push        = 1'b0;
    pbyte       = 8'h00;
    hold_v_next = hold_v_reg;
    hold_d_next = hold_d_reg;
    if (accept) begin
      hold_v_next = 1'b1;
      hold_d_next = in_data;
    end
    if (sel_valid) begin
      if (state_reg == PJS_IDLE) begin
        pend_next   = sel_id;
        pend_v_next = 1'b1;
      end else if (!jobcfg_reg[`PJS_JC_BEGIN])
        cur_next = sel_id;
    end
    unique case (state_reg)
      PJS_IDLE:
        if (hold_v_reg) begin
          cur_next    = sel_valid  ? sel_id
                        : pend_v_reg ? pend_reg : dflt_reg;
          pend_v_next = 1'b0;
          if (jobcfg_reg[`PJS_JC_FFPRE])
            state_next = PJS_FF_PRE;
          else if (jobcfg_reg[`PJS_JC_BANEN] &&
                   !jobcfg_reg[`PJS_JC_BANAFT])
            state_next = PJS_BAN_PRE;
          else
            state_next = PJS_DATA;
        end
      PJS_FF_PRE:
        if (space) begin
          push  = 1'b1;
          pbyte = `PJS_CH_FF;
          state_next = (jobcfg_reg[`PJS_JC_BANEN] &&
                        !jobcfg_reg[`PJS_JC_BANAFT])
                       ? PJS_BAN_PRE : PJS_DATA;
        end
      PJS_BAN_PRE, PJS_BAN_POST:
        if (space) begin
          push     = 1'b1;
          pbyte    = bbyte;
          idx_next = idx_reg + 7'h01;
          if (ban_last) begin
            idx_next = 7'h00;
            if (state_reg == PJS_BAN_PRE)
              state_next = PJS_DATA;
            else
              state_next = jobcfg_reg[`PJS_JC_FFPOST]
                           ? PJS_FF_POST : PJS_IDLE;
          end
        end
      PJS_DATA:
        if (expire || (hold_v_reg && space)) begin
          if (!expire) begin
            hold_v_next = accept;
            push  = !(hold_d_reg == disc_reg &&
                      !jobcfg_reg[`PJS_JC_BEGIN]);
            pbyte = hold_d_reg;
          end
          if (expire || !push) begin
            if (jobcfg_reg[`PJS_JC_BANEN] &&
                jobcfg_reg[`PJS_JC_BANAFT])
              state_next = PJS_BAN_POST;
            else
              state_next = jobcfg_reg[`PJS_JC_FFPOST]
                           ? PJS_FF_POST : PJS_IDLE;
          end
        end
      PJS_FF_POST:
        if (space) begin
          push  = 1'b1;
          pbyte = `PJS_CH_FF;
          state_next = PJS_IDLE;
        end
      default: state_next = PJS_IDLE;
    endcase
    if (!sercfg_reg[`PJS_SC_WORD8])
      pbyte[7] = 1'b0;
    b0_next  = pop ? b1_reg : b0_reg;
    b1_next  = b1_reg;
    c_after  = cnt_reg - {1'b0, pop};
    cnt_next = c_after + {1'b0, push};
    if (push && c_after == 2'h0) b0_next = pbyte;
    if (push && c_after == 2'h1) b1_next = pbyte;
    pause_next = pause_reg;
    if (!sercfg_reg[`PJS_SC_XTX])
      pause_next = 1'b0;
    else if (prn_rx_valid && prn_rx_data == `PJS_CH_XOFF)
      pause_next = 1'b1;
    else if (prn_rx_valid && prn_rx_data == `PJS_CH_XON)
      pause_next = 1'b0;
    ov_next    = cnt_next != 2'h0 && !pause_next;
    rdy_next   = !hold_v_next;
    hstop_next = sercfg_reg[`PJS_SC_XRX] && hold_v_next;
    act_next   = state_next != PJS_IDLE;
    tick_next  = tick ? 26'h000_0000 : tick_reg + 26'h000_0001;
    sec_next   = (tick && sec_reg != 8'hff) ? sec_reg + 8'h01 : sec_reg;
    if (state_reg != PJS_DATA || accept) begin
      tick_next = 26'h000_0000;
      sec_next  = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= PJS_IDLE;
      cur_reg    <= 5'h00;
      pend_reg   <= 5'h00;
      pend_v_reg <= 1'b0;
      idx_reg    <= 7'h00;
      hold_v_reg <= 1'b0;
      hold_d_reg <= 8'h00;
      rdy_reg    <= 1'b0;
      b0_reg     <= 8'h00;
      b1_reg     <= 8'h00;
      cnt_reg    <= 2'h0;
      ov_reg     <= 1'b0;
      pause_reg  <= 1'b0;
      hstop_reg  <= 1'b0;
      act_reg    <= 1'b0;
      tick_reg   <= 26'h000_0000;
      sec_reg    <= 8'h00;
    end else begin
      state_reg  <= state_next;
      cur_reg    <= cur_next;
      pend_reg   <= pend_next;
      pend_v_reg <= pend_v_next;
      idx_reg    <= idx_next;
      hold_v_reg <= hold_v_next;
      hold_d_reg <= hold_d_next;
      rdy_reg    <= rdy_next;
      b0_reg     <= b0_next;
      b1_reg     <= b1_next;
      cnt_reg    <= cnt_next;
      ov_reg     <= ov_next;
      pause_reg  <= pause_next;
      hstop_reg  <= hstop_next;
      act_reg    <= act_next;
      tick_reg   <= tick_next;
      sec_reg    <= sec_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign in_ready        = rdy_reg;
  assign out_valid       = ov_reg;
  assign out_data        = b0_reg;
  assign out_prn         = cur_reg;
  assign cfg_word8       = sercfg_reg[`PJS_SC_WORD8];
  assign cfg_stop2       = sercfg_reg[`PJS_SC_STOP2];
  assign cfg_parity      = sercfg_reg[`PJS_SC_PAR];
  assign cfg_baud        = sercfg_reg[`PJS_SC_BAUD];
  assign cfg_wire8       = sercfg_reg[`PJS_SC_WIRE8];
  assign cfg_bidir       = sercfg_reg[`PJS_SC_BIDIR];
  assign host_stop       = hstop_reg;
  assign job_active      = act_reg;

  // checks
  sequence bus_req_s;
    (avs_read || avs_write) && wait_reg;
  endsequence
  sequence job_start_s;
    state_reg == PJS_IDLE && hold_v_reg;
  endsequence
  logic disc_hit;
  assign disc_hit = state_reg == PJS_DATA && hold_v_reg && space
                    && !expire && hold_d_reg == disc_reg;

  bus_answer_a: assert property (@(posedge clock) disable iff (!rst_b)
    bus_req_s |=> !wait_reg ##1 wait_reg)
    else $error("waitrequest not a single low cycle");
  tmo_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    expire |=> state_reg != PJS_DATA)
    else $error("timeout did not end job");
  tmo_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_reg == PJS_DATA && tmo_reg == 8'h00 && !hold_v_reg
    |=> state_reg == PJS_DATA)
    else $error("zero timeout ended job");
  disc_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    disc_hit && !jobcfg_reg[`PJS_JC_BEGIN]
    |=> state_reg != PJS_DATA && cnt_reg == $past(cnt_reg) - 2'($past(pop)))
    else $error("disconnect code not honoured");
  disc_data_a: assert property (@(posedge clock) disable iff (!rst_b)
    disc_hit && jobcfg_reg[`PJS_JC_BEGIN] |=> state_reg == PJS_DATA)
    else $error("disconnect ended begin-only job");
  sel_mid_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_reg == PJS_DATA && jobcfg_reg[`PJS_JC_BEGIN]
    |=> cur_reg == $past(cur_reg))
    else $error("printer switched mid job");
  ff_pre_a: assert property (@(posedge clock) disable iff (!rst_b)
    job_start_s ##0 jobcfg_reg[`PJS_JC_FFPRE] |=> state_reg == PJS_FF_PRE)
    else $error("leading form feed skipped");
  dflt_use_a: assert property (@(posedge clock) disable iff (!rst_b)
    job_start_s ##0 !pend_v_reg && !sel_valid |=> cur_reg == $past(dflt_reg))
    else $error("default printer not used");
  word7_a: assert property (@(posedge clock) disable iff (!rst_b)
    push && !sercfg_reg[`PJS_SC_WORD8] |-> !pbyte[7])
    else $error("bit 7 passed in 7-bit framing");
  baud_cap_a: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_bidir |-> cfg_baud <= `PJS_BAUD_BIDIR)
    else $error("bidirectional baud above limit");
  timer_rst_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_reg == PJS_DATA && accept |=> sec_reg == 8'h00 && !expire)
    else $error("timer not restarted by host byte");
endmodule

// ---- verification/pjs_printer_model.sv ----
// printer side model for the print job session block
// assumes the session's printer stream and slow/pause controls from the bench
`timescale 1ns/1ps
`include "pjs_defs.svh"
module pjs_printer_model
  import pjs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       slow,
  input  wire logic       pause,
  output logic            out_ready,
  output logic            prn_rx_valid,
  output logic      [7:0] prn_rx_data
);
  logic [7:0] got [$];
  logic [1:0] ph_reg;
  logic       pause_reg;
  // slow mode takes one byte in four cycles
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ph_reg <= 2'h0;
      out_ready <= 1'b0;
      pause_reg <= 1'b0;
      prn_rx_valid <= 1'b0;
      prn_rx_data <= 8'h00;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      out_ready <= !slow || ph_reg == 2'h3;
      if (out_valid && out_ready) begin
        got.push_back(out_data);
      end
      pause_reg <= pause;
      prn_rx_valid <= pause != pause_reg;
      // data line toggles between flow control bytes
      prn_rx_data <= (pause != pause_reg) ?
                     (pause ? `PJS_CH_XOFF : `PJS_CH_XON) : ~prn_rx_data;
    end
  end
endmodule

// ---- verification/pjs_session_test.sv ----
// self-checking bench for the print job session block
// assumes the printer model beside it and a 50 MHz clock
`timescale 1ns/1ps
`include "pjs_defs.svh"
module pjs_session_test
  import pjs_pkg::*;
;
  typedef struct {
    logic        wr;
    logic [9:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } pjs_row_t;
  logic        clock, rst_b, avs_read, avs_write, in_valid, sel_valid;
  logic        slow, pause, avs_waitrequest, in_ready, prn_rx_valid;
  logic        out_valid, out_ready, cfg_word8, cfg_stop2, cfg_wire8;
  logic        cfg_bidir, host_stop, job_active;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  in_data, prn_rx_data, out_data;
  logic [7:0]  exp_q [$];
  logic [4:0]  sel_id, out_prn;
  logic [1:0]  cfg_parity;
  logic [3:0]  cfg_baud;
  int          mismatches, n_tests;
  pjs_row_t    rows [17];

  pjs_session #(.TICK_CYCLES(10)) pjs_session_inst (
    .clock(clock), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_data(in_data), .in_ready(in_ready), .sel_valid(sel_valid),
    .sel_id(sel_id), .prn_rx_valid(prn_rx_valid),
    .prn_rx_data(prn_rx_data), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .out_prn(out_prn),
    .cfg_word8(cfg_word8), .cfg_stop2(cfg_stop2),
    .cfg_parity(cfg_parity), .cfg_baud(cfg_baud), .cfg_wire8(cfg_wire8),
    .cfg_bidir(cfg_bidir), .host_stop(host_stop), .job_active(job_active));
  pjs_printer_model pjs_printer_model_inst (
    .clock(clock), .rst_b(rst_b), .out_valid(out_valid),
    .out_data(out_data), .slow(slow), .pause(pause),
    .out_ready(out_ready), .prn_rx_valid(prn_rx_valid),
    .prn_rx_data(prn_rx_data));

  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cmp(input string w, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task cmp_bit(input string w, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", w, e, s);
    end
  endtask
  task fail_wait(input string w);
    cmp_bit(w, 1'b1, 1'b0);
    wrap_up();
  endtask
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) fail_wait("waitrequest");
  endtask
  task send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clock);
    in_valid <= 1'b1;
    in_data <= b;
    do begin
      @(posedge clock);
      n++;
    end while (in_ready !== 1'b1 && n < 200);
    in_valid <= 1'b0;
    if (n >= 200) fail_wait("in_ready");
  endtask
  task check_stream(input string w);
    int n;
    n = 0;
    while (pjs_printer_model_inst.got.size() < exp_q.size() && n < 2000)
    begin
      @(posedge clock);
      n++;
    end
    cmp({w, " count"}, exp_q.size(), pjs_printer_model_inst.got.size());
    foreach (exp_q[i]) cmp(w, exp_q[i], pjs_printer_model_inst.got[i]);
    pjs_printer_model_inst.got.delete();
    if (n >= 2000) fail_wait(w);
  endtask
  task wait_idle(input int lim);
    int n;
    n = 0;
    while (job_active !== 1'b0 && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (n >= lim) fail_wait("job_active");
  endtask
  task bus_ok(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task select(input logic [4:0] id);
    sel_valid <= 1'b1;
    sel_id <= id;
    @(posedge clock);
    sel_valid <= 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    {rst_b, avs_read, avs_write, in_valid, sel_valid, slow, pause} = 7'h0;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    in_data = 8'h00;
    sel_id = 5'h00;
    rows = '{'{0, `PJS_A_SERCFG, 0, 32'h5c1}, '{0, `PJS_A_TMO, 0, 32'h14},
      '{0, `PJS_A_JOBCFG, 0, 0}, '{0, `PJS_A_DISC, 0, 32'h04},
      '{0, `PJS_A_MSGLEN, 0, 0}, '{0, `PJS_A_DFLT, 0, 0},
      '{0, `PJS_A_STATUS, 0, 0}, '{0, 10'h3f0, 0, 0},
      '{1, `PJS_A_TMO, 32'hff, 32'hc8}, '{1, `PJS_A_MSGLEN, 32'h64, 32'h50},
      '{1, `PJS_A_SERCFG, 32'hf41, 32'h841},
      '{1, `PJS_A_SERCFG, 32'hf81, 32'ha81}, '{1, 10'h3f0, 32'h5, 0},
      '{1, `PJS_A_PRNMAP, 0, 0}, '{1, `PJS_A_DFLT, 32'h3, 0},
      '{1, `PJS_A_PRNMAP, 32'h8, 32'h8}, '{1, `PJS_A_DFLT, 32'h3, 32'h3}};
    repeat (6) @(posedge clock);
    cmp("reset outputs", 32'h8085c, {avs_waitrequest, in_ready, out_valid,
      out_prn, cfg_word8, cfg_stop2, cfg_parity, cfg_baud, cfg_wire8,
      cfg_bidir, host_stop, job_active});
    rst_b <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    cmp_bit("in_ready", 1'b1, in_ready);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].wr) bus_ok(rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      cmp("register", rows[i].e, rd);
    end
    bus_ok(`PJS_A_SERCFG, 32'h20a);
    @(posedge clock);
    cmp("cfg outputs", 32'h188, {22'h0, cfg_word8, cfg_stop2, cfg_parity,
      cfg_baud, cfg_wire8, cfg_bidir});
    $display("test registers done");
    // job to default printer, form feeds, ended by disconnect
    bus_ok(`PJS_A_TMO, 32'h0);
    bus_ok(`PJS_A_JOBCFG, 32'h3);
    slow <= 1'b1;
    send(8'h41);
    send(8'h42);
    repeat (2) @(posedge clock);
    cmp("out_prn", 32'h3, {27'h0, out_prn});
    select(5'h05);
    repeat (2) @(posedge clock);
    cmp("out_prn", 32'h5, {27'h0, out_prn});
    send(`PJS_DISC_RST);
    exp_q = '{`PJS_CH_FF, 8'h41, 8'h42, `PJS_CH_FF};
    check_stream("ff job");
    wait_idle(40);
    $display("test disconnect done");
    // beginning-only mode: timeout only, mid-job select is ignored
    bus_ok(`PJS_A_TMO, 32'h3);
    bus_ok(`PJS_A_JOBCFG, 32'h10);
    slow <= 1'b0;
    send(8'h55);
    repeat (2) @(posedge clock);
    select(5'h05);
    send(`PJS_DISC_RST);
    repeat (15) @(posedge clock);
    cmp_bit("job_active", 1'b1, job_active);
    send(8'h66);
    repeat (15) @(posedge clock);
    cmp_bit("job_active", 1'b1, job_active);
    cmp("out_prn", 32'h3, {27'h0, out_prn});
    wait_idle(40);
    bus(1'b0, `PJS_A_STATUS, 32'h0);
    cmp("state", {29'h0, PJS_IDLE}, {29'h0, rd[3:1]});
    exp_q = '{8'h55, `PJS_DISC_RST, 8'h66};
    check_stream("begin job");
    $display("test beginning mode done");
    // seven-bit framing, banner after the job
    bus_ok(`PJS_A_SERCFG, 32'ha80);
    bus_ok(`PJS_A_MSGLEN, 32'h2);
    bus_ok(10'h200, 32'h1b);
    bus_ok(10'h204, 32'h48);
    exp_q = '{8'h41, 8'h1b, 8'h48};
    for (int i = 0; i < 16; i++) begin
      bus_ok(10'h100 + 10'(4 * i), 32'h61 + i);
      exp_q.push_back(8'h61 + 8'(i));
    end
    bus_ok(`PJS_A_TMO, 32'h0);
    bus_ok(`PJS_A_JOBCFG, 32'hc);
    send(8'hc1);
    send(`PJS_DISC_RST);
    check_stream("banner job");
    wait_idle(100);
    $display("test banner done");
    // flow control pause fills the buffer and asks the host to stop
    bus_ok(`PJS_A_SERCFG, 32'hab1);
    bus_ok(`PJS_A_JOBCFG, 32'h0);
    select(5'h07);
    pause <= 1'b1;
    repeat (4) @(posedge clock);
    send(8'h71);
    send(8'h72);
    send(8'h73);
    repeat (4) @(posedge clock);
    cmp_bit("out_valid", 1'b0, out_valid);
    cmp_bit("host_stop", 1'b1, host_stop);
    cmp_bit("in_ready", 1'b0, in_ready);
    cmp("out_prn", 32'h7, {27'h0, out_prn});
    pause <= 1'b0;
    send(`PJS_DISC_RST);
    exp_q = '{8'h71, 8'h72, 8'h73};
    check_stream("paused job");
    wait_idle(40);
    cmp_bit("host_stop", 1'b0, host_stop);
    $display("test flow control done");
    // reset in mid job clears the session and reloads the register reset values
    send(8'h77);
    rst_b <= 1'b0;
    @(posedge clock);
    cmp("mid reset", 32'h8, {28'h0, avs_waitrequest, in_ready, out_valid,
      job_active});
    rst_b <= 1'b1;
    bus(1'b0, `PJS_A_TMO, 32'h0);
    cmp("tmo after reset", 32'h14, rd);
    pjs_printer_model_inst.got.delete();
    $display("test mid reset done");
    wrap_up();
  end
endmodule
